/* rtl/desb_map.vh */
// constants for the error status buffer block
// assumes inclusion by bare name from rtl files
`ifndef DESB_MAP_VH
`define DESB_MAP_VH
`define DESB_ADDR_W 4
`define DESB_ADDR_STB_BASE 4'h0
`define DESB_ADDR_STB_LAST 4'hb
`define DESB_ADDR_OPSTAT 4'hc
`define DESB_ADDR_CTRL 4'hd
`define DESB_ADDR_LTSTAT 4'he
`define DESB_NBYTES 12
`define DESB_MARK_SET 8'hff
`define DESB_BYTE_ZERO 8'h00
`define DESB_OPS_ERR 7
`define DESB_OPS_HARD 6
`define DESB_OPS_UNIT_LO 4
`define DESB_CTRL_SEL_LT 0
`define DESB_S0_BADFN 0
`define DESB_S0_BADMOD 1
`define DESB_S0_BADDRV 2
`define DESB_S0_RAM 3
`define DESB_S0_ROM 4
`define DESB_S0_BUSY 5
`define DESB_S0_ILLEGAL 6
`define DESB_S0_EOM 7
`endif

/* rtl/desb_status_buffer.v */
// error status buffer builder and operation status summariser
// assumes the function engine gives a one-cycle post pulse with its result fields
// Function
// RL1: bytes 0-2 hold the detailed error status of the last completed function
// RL2: disk bytes 3-6 hold requested cylinder low, high, head/volume, sector
// RL3: disk bytes 7-10 hold actual cylinder low, flags/high, head/volume, sector
// RL4: disk byte 11 holds the retry count of the function
// RL5: tape byte 3 is ff when beginning-of-tape marker was found
// RL6: tape byte 4 is ff when logical load point was detected
// RL7: tape byte 5 is ff when a file mark was met
// RL8: tape byte 6 is ff when logical end of tape was met
// RL9: tape byte 8 is ff when only blank tape was read
// RL10: tape bytes 7, 9 and 10 read as zero
// RL11: op status bit 7 set when any bit of bytes 0-2 is one
// RL12: op status bit 6 gives hard(1)/soft(0) when bytes 0 or 1 nonzero
// RL13: byte 0 bit 0 set for an undefined function code
// RL14: byte 0 bit 1 tape module cannot execute code; zero for disk
// RL15: byte 0 bit 2 tape drive cannot execute code; zero for disk
// RL16: byte 0 bit 3 internal RAM test failure; zero for tape
// RL17: byte 0 bit 4 ROM checksum failure, controller or tape module
// RL18: byte 0 bit 5 drive still busy with off-line seek or long-term function
// RL19: disk byte 0 bit 6 alternate track misuse or illegal code/unit
// RL20: tape byte 0 bit 6 drive not present or illegal code/unit
// RL21: byte 0 bit 7 end of medium before transfer count satisfied
// RL22: op status bits 0-3 summary code, bits 4-5 unit number
// RL23: short-term posted at completion; long-term posted after off-line end
// RL24: all twelve bytes cleared before a function posts results
// RL25: host reads the buffer after an error summary, before the next function
//
// Added by the designer: strobed register access and the address map.
`include "desb_map.vh"
module desb_status_buffer #(
    parameter NBYTES = 12
) (
    input wire clk_sys,
    input wire nrst,
    input wire clk_en,
    input wire [`DESB_ADDR_W-1:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    input wire post_st,
    input wire post_lt,
    input wire is_tape,
    input wire [1:0] unit_num,
    input wire [3:0] summary_code,
    input wire fn_undefined,
    input wire tape_mod_reject,
    input wire tape_drv_reject,
    input wire ram_fail,
    input wire rom_fail,
    input wire drive_busy,
    input wire alt_track_misuse,
    input wire not_configured,
    input wire illegal_param,
    input wire end_of_medium,
    input wire [7:0] detail1,
    input wire [7:0] detail2,
    input wire hard_error,
    input wire [7:0] req_cyl_lo,
    input wire [7:0] req_cyl_hi,
    input wire [7:0] req_head,
    input wire [7:0] req_sector,
    input wire [7:0] act_cyl_lo,
    input wire [7:0] act_flags_hi,
    input wire [7:0] act_head,
    input wire [7:0] act_sector,
    input wire [7:0] retry_count,
    input wire tape_bot,
    input wire tape_load_pt,
    input wire tape_file_mark,
    input wire tape_eot,
    input wire tape_blank,
    output reg [7:0] op_status,
    output reg lt_posted
);
    reg [7:0] st_buf_q [0:NBYTES-1];
    reg [7:0] lt_buf_q [0:NBYTES-1];
    reg [7:0] new_byte [0:NBYTES-1];
    reg [7:0] lt_op_q;
    reg sel_lt_q;
    reg [7:0] s0;
    reg [7:0] ops_d;
    reg any_err;
    reg any_hard;
    integer i;
    integer k;

    // detailed status byte 0 per function class
    always @* begin
        s0 = `DESB_BYTE_ZERO;
        s0[`DESB_S0_BADFN] = fn_undefined; // RL13
        s0[`DESB_S0_BADMOD] = is_tape & tape_mod_reject; // RL14
        s0[`DESB_S0_BADDRV] = is_tape & tape_drv_reject; // RL15
        s0[`DESB_S0_RAM] = ~is_tape & ram_fail; // RL16
        s0[`DESB_S0_ROM] = rom_fail; // RL17
        s0[`DESB_S0_BUSY] = drive_busy; // RL18
        if (is_tape) begin
            s0[`DESB_S0_ILLEGAL] = not_configured | illegal_param; // RL20
        end else begin
            s0[`DESB_S0_ILLEGAL] = alt_track_misuse | illegal_param; // RL19
        end
        s0[`DESB_S0_EOM] = end_of_medium; // RL21
    end

    // assemble the twelve bytes, undefined ones start at zero
    always @* begin
        for (k = 0; k < NBYTES; k = k + 1) begin
            new_byte[k] = `DESB_BYTE_ZERO; // RL24 RL10
        end
        new_byte[0] = s0; // RL1
        new_byte[1] = detail1; // RL1
        new_byte[2] = detail2; // RL1
        if (is_tape) begin
            new_byte[3] = tape_bot ? `DESB_MARK_SET : `DESB_BYTE_ZERO; // RL5
            new_byte[4] = tape_load_pt ? `DESB_MARK_SET : `DESB_BYTE_ZERO; // RL6
            new_byte[5] = tape_file_mark ? `DESB_MARK_SET : `DESB_BYTE_ZERO; // RL7
            new_byte[6] = tape_eot ? `DESB_MARK_SET : `DESB_BYTE_ZERO; // RL8
            new_byte[8] = tape_blank ? `DESB_MARK_SET : `DESB_BYTE_ZERO; // RL9
        end else begin
            new_byte[3] = req_cyl_lo; // RL2
            new_byte[4] = req_cyl_hi; // RL2
            new_byte[5] = req_head; // RL2
            new_byte[6] = req_sector; // RL2
            new_byte[7] = act_cyl_lo; // RL3
            new_byte[8] = act_flags_hi; // RL3
            new_byte[9] = act_head; // RL3
            new_byte[10] = act_sector; // RL3
            new_byte[11] = retry_count; // RL4
        end
    end

    // fold the detail bytes into the summary byte
    always @* begin
        any_err = (|s0) | (|detail1) | (|detail2); // RL11
        any_hard = ((|s0) | (|detail1)) & hard_error; // RL12
        ops_d = {any_err, any_hard, unit_num, summary_code}; // RL22
    end

    // post buffers; long-term also refreshes short-term
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            for (i = 0; i < NBYTES; i = i + 1) begin
                st_buf_q[i] <= `DESB_BYTE_ZERO;
                lt_buf_q[i] <= `DESB_BYTE_ZERO;
            end
            op_status <= `DESB_BYTE_ZERO;
            lt_op_q <= `DESB_BYTE_ZERO;
            lt_posted <= 1'b0;
        end else if (clk_en) begin
            if (post_st | post_lt) begin
                for (i = 0; i < NBYTES; i = i + 1) begin
                    st_buf_q[i] <= new_byte[i]; // RL23 RL24
                end
                op_status <= ops_d; // RL11 RL12 RL22
            end
            if (post_lt) begin
                for (i = 0; i < NBYTES; i = i + 1) begin
                    lt_buf_q[i] <= new_byte[i]; // RL23
                end
                lt_op_q <= ops_d;
            end
            lt_posted <= post_lt;
        end
    end

    // control register selects which buffer the host reads
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sel_lt_q <= 1'b0;
        end else if (clk_en && reg_wr && reg_addr == `DESB_ADDR_CTRL) begin
            sel_lt_q <= reg_wdata[`DESB_CTRL_SEL_LT];
        end
    end

    // read data one cycle after the strobe, zero elsewhere
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            reg_rdata <= `DESB_BYTE_ZERO;
        end else if (clk_en) begin
            reg_rdata <= `DESB_BYTE_ZERO;
            if (reg_rd) begin
                if (reg_addr <= `DESB_ADDR_STB_LAST) begin
                    reg_rdata <= sel_lt_q ? lt_buf_q[reg_addr] : st_buf_q[reg_addr]; // RL25
                end else if (reg_addr == `DESB_ADDR_OPSTAT) begin
                    reg_rdata <= op_status;
                end else if (reg_addr == `DESB_ADDR_CTRL) begin
                    reg_rdata <= {7'h00, sel_lt_q};
                end else if (reg_addr == `DESB_ADDR_LTSTAT) begin
                    reg_rdata <= lt_op_q;
                end
            end
        end
    end
endmodule // desb_status_buffer

/* sim/desb_status_buffer_properties.sv */
// port assertions for the error status buffer
// assumes binding onto desb_status_buffer, one clock domain
`include "desb_map.vh"
module desb_status_buffer_checker (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic clk_en,
    input wire logic reg_rd,
    input wire logic post_st,
    input wire logic post_lt,
    input wire logic is_tape,
    input wire logic hard_error,
    input wire logic fn_undefined,
    input wire logic tape_mod_reject,
    input wire logic tape_drv_reject,
    input wire logic ram_fail,
    input wire logic rom_fail,
    input wire logic drive_busy,
    input wire logic alt_track_misuse,
    input wire logic not_configured,
    input wire logic illegal_param,
    input wire logic end_of_medium,
    input wire logic lt_posted,
    input wire logic [1:0] unit_num,
    input wire logic [3:0] summary_code,
    input wire logic [`DESB_ADDR_W-1:0] reg_addr,
    input wire logic [7:0] detail1,
    input wire logic [7:0] detail2,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] op_status
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic [7:0] b0 = {end_of_medium, illegal_param | (is_tape ? not_configured :
        alt_track_misuse), drive_busy, rom_fail, ram_fail & !is_tape,
        tape_drv_reject & is_tape, tape_mod_reject & is_tape, fn_undefined};
    wire logic pst = clk_en & (post_st | post_lt);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    property p_err; pst |=> op_status[7] == $past(|{b0, detail1, detail2}); endproperty
    a_err: assert property (p_err) else $error("error summary wrong");
    property p_hard; pst |=> op_status[6] == $past(hard_error & |{b0, detail1}); endproperty
    a_hard: assert property (p_hard) else $error("hard bit wrong");
    property p_unit; pst |=> op_status[5:0] == $past({unit_num, summary_code}); endproperty
    a_unit: assert property (p_unit) else $error("unit or summary wrong");
    property p_hold; clk_en && !post_st && !post_lt |=> $stable(op_status); endproperty
    a_hold: assert property (p_hold) else $error("op status moved");
    property p_lt; clk_en |=> lt_posted == $past(post_lt); endproperty
    a_lt: assert property (p_lt) else $error("long-term flag wrong");
    property p_ops; clk_en && reg_rd && reg_addr == `DESB_ADDR_OPSTAT |=>
        reg_rdata == $past(op_status); endproperty
    a_ops: assert property (p_ops) else $error("op status read wrong");
    property p_rdz; clk_en && !reg_rd |=> reg_rdata == 8'h00; endproperty
    a_rdz: assert property (p_rdz) else $error("idle read data");
    property p_ram; pst && is_tape && ram_fail && !(|{b0, detail1, detail2}) |=>
        !op_status[7]; endproperty
    a_ram: assert property (p_ram) else $error("ram fail on tape");
endmodule // desb_status_buffer_checker
bind desb_status_buffer desb_status_buffer_checker desb_status_buffer_checker_inst (.*);

/* sim/desb_host.sv */
// host model on the register port
// assumes one clock, signals changed just after rising edges
module desb_host (
    input wire logic clk_sys,
    input wire logic [7:0] reg_rdata,
    output logic [3:0] reg_addr = 4'h0,
    output logic [7:0] reg_wdata = 8'h00,
    output logic reg_wr = 1'b0,
    output logic reg_rd = 1'b0
);
    timeunit 1ns;
    timeprecision 1ps;
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_wdata <= ~v;
    endtask
    // buffer read only after posting, before the next post
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
endmodule // desb_host

/* sim/test_disk_tape_error_status_buffer.sv */
// self-checking bench for the error status buffer
// assumes the host model for every register access
`include "desb_map.vh"
module test_disk_tape_error_status_buffer;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0, nrst = 1'b0, clk_en = 1'b1, post_st = 1'b0, post_lt = 1'b0;
    logic is_tape = 1'b0, hard_error = 1'b0;
    logic [5:0] us = 6'h00;
    logic [9:0] c = 10'h000;
    logic [4:0] m = 5'h00;
    logic [7:0] f [0:10];
    logic [7:0] ex [0:12], lx [0:12];
    logic [7:0] d;
    wire [7:0] reg_rdata, reg_wdata, op_status;
    wire [3:0] reg_addr;
    wire reg_rd, reg_wr, lt_posted;
    int miscompares = 0, checks_done = 0, cyc = 0;
    always #5 clk_sys = ~clk_sys;
    desb_host desb_host_inst (.*);
    desb_status_buffer desb_status_buffer_inst (.*, .unit_num(us[5:4]), .summary_code(us[3:0]),
        .fn_undefined(c[0]), .tape_mod_reject(c[1]), .tape_drv_reject(c[2]), .ram_fail(c[3]),
        .rom_fail(c[4]), .drive_busy(c[5]), .alt_track_misuse(c[6]), .not_configured(c[7]),
        .illegal_param(c[8]), .end_of_medium(c[9]), .detail1(f[0]), .detail2(f[1]),
        .req_cyl_lo(f[2]), .req_cyl_hi(f[3]), .req_head(f[4]), .req_sector(f[5]),
        .act_cyl_lo(f[6]), .act_flags_hi(f[7]), .act_head(f[8]), .act_sector(f[9]),
        .retry_count(f[10]), .tape_bot(m[0]), .tape_load_pt(m[1]), .tape_file_mark(m[2]),
        .tape_eot(m[3]), .tape_blank(m[4]));
    task automatic cmp(input logic [7:0] seen, input logic [7:0] want);
        checks_done++;
        if (seen !== want) begin
            miscompares++;
            $display("[FAIL] %0t ns: read %h, expected %h", $time, seen, want);
        end
    endtask
    task automatic report_and_stop;
        if (miscompares == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic post(input logic tp, lt, hd, input logic [9:0] cc, input logic [4:0] mm,
            input logic [7:0] d1, d2);
        @(posedge clk_sys);
        is_tape <= tp;
        hard_error <= hd;
        c <= cc;
        m <= mm;
        f[0] <= d1;
        f[1] <= d2;
        us <= us + 6'h17;
        post_st <= !lt;
        post_lt <= lt;
        @(posedge clk_sys);
        post_st <= 1'b0;
        post_lt <= 1'b0;
        #1;
        ex[0] = {cc[9], cc[8] | (tp ? cc[7] : cc[6]), cc[5:4], cc[3] & !tp, cc[2:1] & {2{tp}}, cc[0]};
        for (int i = 1; i < 12; i++) ex[i] = (i < 3 || !tp) ? f[i - 1] : 8'h00;
        if (tp) for (int i = 0; i < 5; i++) ex[i > 3 ? 8 : i + 3] = {8{mm[i]}};
        ex[12] = {|{ex[0], d1, d2}, hd & |{ex[0], d1}, us};
        if (lt) lx = ex;
        cmp(op_status, ex[12]);
        cmp({7'h00, lt_posted}, {7'h00, lt});
    endtask
    task automatic chk(input logic sel);
        desb_host_inst.wr(`DESB_ADDR_CTRL, {7'h00, sel});
        for (int i = 0; i < 13; i++) begin
            desb_host_inst.rd(i < 12 ? 4'(i) : (sel ? `DESB_ADDR_LTSTAT : `DESB_ADDR_OPSTAT), d);
            cmp(d, sel ? lx[i] : ex[i]);
        end
    endtask
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            miscompares++;
            report_and_stop;
        end
    end
    initial begin
        for (int i = 0; i < 11; i++) f[i] = 8'(i * 29 + 7);
        repeat (6) @(posedge clk_sys);
        nrst <= 1'b1;
        post(0, 0, 1, 10'h000, 5'h1f, 8'h00, 8'h08);
        chk(0);
        post(1, 0, 1, 10'h000, 5'h1b, 8'h10, 8'h00);
        chk(0);
        for (int t = 0; t < 2; t++)
            for (int i = 0; i < 10; i++) begin
                post(t[0], 0, i[0], 10'h001 << i, 5'h00, 8'h00, 8'h00);
                desb_host_inst.rd(`DESB_ADDR_STB_BASE, d);
                cmp(d, ex[0]);
            end
        post(1, 1, 0, 10'h020, 5'h05, 8'h00, 8'h00);
        post(0, 0, 1, 10'h200, 5'h00, 8'h01, 8'h00);
        desb_host_inst.wr(4'h3, 8'h5a);
        chk(1);
        chk(0);
        desb_host_inst.rd(4'hf, d);
        cmp(d, 8'h00);
        @(posedge clk_sys);
        clk_en <= 1'b0;
        post_st <= 1'b1;
        c <= 10'h3ff;
        @(posedge clk_sys);
        post_st <= 1'b0;
        clk_en <= 1'b1;
        #1;
        cmp(op_status, ex[12]);
        desb_host_inst.rd(`DESB_ADDR_STB_BASE, d);
        cmp(d, ex[0]);
        nrst <= 1'b0;
        @(posedge clk_sys);
        nrst <= 1'b1;
        #1;
        cmp(op_status, 8'h00);
        desb_host_inst.rd(`DESB_ADDR_STB_BASE, d);
        cmp(d, 8'h00);
        report_and_stop;
    end
endmodule // test_disk_tape_error_status_buffer
